// ===== verilog/ipr_resolver.sv
// Interrupt priority resolver top: samples flags once per machine cycle,
// resolves, and requests a long call from the core sequencer.
// Assumes flags and core strobes come from logic on mclk.
module ipr_resolver
#(
   parameter int NUM_SRC = ipr_pkg::NUM_SRC
)
(
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   // Peripheral flags
   input  wire logic                  ext_int0_flag,
   input  wire logic                  brownout_flag,
   input  wire logic                  watchdog_int_flag,
   input  wire logic                  timer0_overflow_flag,
   input  wire logic                  twi_flag,
   input  wire logic                  converter_done_flag,
   input  wire logic                  ext_int1_flag,
   input  wire logic                  keypad_flag,
   input  wire logic                  comparator1_flag,
   input  wire logic                  timer1_overflow_flag,
   input  wire logic                  comparator2_flag,
   input  wire logic                  serial_rx_flag,
   input  wire logic                  serial_tx_flag,
   input  wire logic                  pwm_brake_flag,
   // Configuration
   input  wire logic                  global_enable,
   input  wire logic [NUM_SRC-1:0]    source_enable,
   input  wire logic [NUM_SRC-1:0]    priority_low_bits,
   input  wire logic [NUM_SRC-1:0]    priority_high_bits,
   // Core sequencer status
   input  wire logic                  last_cycle_of_insn,
   input  wire logic                  insn_writes_int_cfg,
   input  wire logic                  return_from_interrupt,
   // Outputs
   output logic                       long_subroutine_call,
   output logic [ipr_pkg::SRC_W-1:0]  vector_source,
   output logic [ipr_pkg::NUM_LVL-1:0] in_service,
   output logic [1:0]                 machine_state
);

   // ----------------------------------------------------------------
   // Machine cycle state counter
   // ----------------------------------------------------------------
   // Free-running; the core keeps its own count of instruction cycles
   // Limitation: both-edge timing inside a state is not modelled
   ipr_pkg::ipr_state_t state_ff;
   ipr_pkg::ipr_state_t nxt_state;

   always_comb
   begin
      case (state_ff)                                         // [R8]
         ipr_pkg::IPR_C1: nxt_state = ipr_pkg::IPR_C2;
         ipr_pkg::IPR_C2: nxt_state = ipr_pkg::IPR_C3;
         ipr_pkg::IPR_C3: nxt_state = ipr_pkg::IPR_C4;
         ipr_pkg::IPR_C4: nxt_state = ipr_pkg::IPR_C1;
         default:         nxt_state = ipr_pkg::IPR_C1;
      endcase
   end

   // ----------------------------------------------------------------
   // Raw request vector, hierarchy order
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] raw_req;
   assign raw_req[ipr_pkg::SRC_EXT0]   = ext_int0_flag;
   assign raw_req[ipr_pkg::SRC_BROWN]  = brownout_flag;
   assign raw_req[ipr_pkg::SRC_WDOG]   = watchdog_int_flag;
   assign raw_req[ipr_pkg::SRC_TMR0]   = timer0_overflow_flag;
   assign raw_req[ipr_pkg::SRC_TWI]    = twi_flag;
   assign raw_req[ipr_pkg::SRC_CONV]   = converter_done_flag;
   assign raw_req[ipr_pkg::SRC_EXT1]   = ext_int1_flag;
   assign raw_req[ipr_pkg::SRC_KEYPAD] = keypad_flag;
   assign raw_req[ipr_pkg::SRC_CMP1]   = comparator1_flag;
   assign raw_req[ipr_pkg::SRC_TMR1]   = timer1_overflow_flag;
   assign raw_req[ipr_pkg::SRC_CMP2]   = comparator2_flag;
   assign raw_req[ipr_pkg::SRC_SERIAL] = serial_rx_flag
                                         | serial_tx_flag; // [R6]
   assign raw_req[ipr_pkg::SRC_BRAKE]  = pwm_brake_flag;

   // ----------------------------------------------------------------
   // Sampling in C1; samples are replaced each machine cycle, held until the next C1
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] sample_ff;
   logic [NUM_SRC-1:0] nxt_sample;
   wire  sample_now = (state_ff == ipr_pkg::IPR_C1);

   assign nxt_sample = sample_now ? (raw_req & source_enable
                                     & {NUM_SRC{global_enable}}) // [R15] [R7]
                                  : sample_ff;               // [R13]

   // ----------------------------------------------------------------
   // Per-source level from two bits
   // ----------------------------------------------------------------
   ipr_poll_if poll ();
   assign poll.req = sample_ff;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++)
      begin : g_lvl
         assign poll.lvl[2*g +: 2] = {priority_high_bits[g],
                                      priority_low_bits[g]}; // [R2] [R15]
      end
   endgenerate

   ipr_arbiter u_arb
   (
      .p (poll.arb)
   );

   // ----------------------------------------------------------------
   // Admission
   // ----------------------------------------------------------------
   logic [ipr_pkg::NUM_LVL-1:0] in_service_ff;
   logic [ipr_pkg::NUM_LVL-1:0] nxt_in_service;
   // Busy if any level at or above the winner is in service
   logic [ipr_pkg::NUM_LVL-1:0] at_or_above;
   generate
      for (g = 0; g < ipr_pkg::NUM_LVL; g++)
      begin : g_cmp
         assign at_or_above[g] = (g >= int'(poll.win_lvl));
      end
   endgenerate

   wire blocked  = |(in_service_ff & at_or_above);           // [R3] [R10]
   wire poll_now = (state_ff == ipr_pkg::IPR_C4);             // [R7]
   wire admit    = poll_now && poll.found && !blocked
                   && last_cycle_of_insn                       // [R11]
                   && !insn_writes_int_cfg
                   && !return_from_interrupt;                 // [R12]

   // ----------------------------------------------------------------
   // In-service record
   // ----------------------------------------------------------------
   logic [ipr_pkg::NUM_LVL-1:0] top_bit;

   // The return closes the most urgent level active, as handlers nest
   always_comb
   begin
      top_bit = '0;
      for (int i = 0; i < ipr_pkg::NUM_LVL; i++)
      begin
         if (in_service_ff[i])
         begin
            top_bit = '0;
            top_bit[i] = 1'b1;
         end
      end
   end

   // Admit is never true with a return, so set and clear never collide
   wire ret_done = return_from_interrupt && last_cycle_of_insn && poll_now;
   logic [ipr_pkg::NUM_LVL-1:0] set_bit;
   always_comb
   begin
      set_bit = '0;
      set_bit[poll.win_lvl] = admit;                          // [R9]
   end

   assign nxt_in_service = (in_service_ff & ~(ret_done ? top_bit : '0))
                           | set_bit;                          // [R14]

   // ----------------------------------------------------------------
   // Registers, one short process each
   // ----------------------------------------------------------------
   logic                        call_ff;
   logic                        nxt_call;
   logic [ipr_pkg::SRC_W-1:0]   vector_ff;
   logic [ipr_pkg::SRC_W-1:0]   nxt_vector;

   assign nxt_call   = admit;                                 // [R9]
   // Vector holds between calls so the core may fetch it late
   assign nxt_vector = admit ? poll.win_src : vector_ff;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         state_ff <= ipr_pkg::IPR_C1;
      else
         state_ff <= nxt_state;                               // [R8]
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         sample_ff <= '0;
      else
         sample_ff <= nxt_sample;                             // [R7]
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         in_service_ff <= ipr_pkg::RST_IN_SERVICE;
      else
         in_service_ff <= nxt_in_service;                     // [R14]
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         call_ff <= 1'b0;
      else
         call_ff <= nxt_call;                                 // [R9]
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         vector_ff <= ipr_pkg::RST_VECTOR;
      else
         vector_ff <= nxt_vector;
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign long_subroutine_call = call_ff;
   assign vector_source        = vector_ff;
   assign in_service           = in_service_ff;
   assign machine_state        = state_ff;

endmodule // ipr_resolver

// ===== verilog/ipr_pkg.sv
// Package for the interrupt priority resolver: source order, levels,
// machine cycle timing.
// Assumes one clock (mclk, 50 MHz) shared with the processor core.
//
// Behaviour
// (R1) Four priority levels, highest down to lowest.
// (R2) Each source's priority configured independently.
// (R3) Lower level never preempts running handler.
// (R4) Same-level ties settled by fixed hierarchy.
// (R5) Hierarchy: int0 first, PWM brake last.
// (R6) Serial request is receive OR transmit.
// (R7) Flags sampled and resolved each machine cycle.
// (R8) Machine cycle is four clock states.
// (R9) Admitted request issues long call to vector.
// (R10) No call while equal/higher level serviced.
// (R11) Call only in instruction's last cycle.
// (R12) No call on priority/enable write or return.
// (R13) Denied requests are not remembered.
// (R14) In-service bit per level, cleared by return.
// (R15) Two priority bits per source; enables gate polling.
package ipr_pkg;

   // ----------------------------------------------------------------
   // Sources in hierarchy order, index 0 is the highest
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 13;
   localparam int SRC_W   = 4;
   localparam logic [3:0] SRC_EXT0    = 4'h0;
   localparam logic [3:0] SRC_BROWN   = 4'h1;
   localparam logic [3:0] SRC_WDOG    = 4'h2;
   localparam logic [3:0] SRC_TMR0    = 4'h3;
   localparam logic [3:0] SRC_TWI     = 4'h4;
   localparam logic [3:0] SRC_CONV    = 4'h5;
   localparam logic [3:0] SRC_EXT1    = 4'h6;
   localparam logic [3:0] SRC_KEYPAD  = 4'h7;
   localparam logic [3:0] SRC_CMP1    = 4'h8;
   localparam logic [3:0] SRC_TMR1    = 4'h9;
   localparam logic [3:0] SRC_CMP2    = 4'hA;
   localparam logic [3:0] SRC_SERIAL  = 4'hB;
   localparam logic [3:0] SRC_BRAKE   = 4'hC;

   // ----------------------------------------------------------------
   // Priority levels; larger code is more urgent
   // ----------------------------------------------------------------
   localparam int NUM_LVL = 4;
   typedef enum logic [1:0]
   {
      IPR_LVL_LOWEST  = 2'b00,
      IPR_LVL_LOW     = 2'b01,
      IPR_LVL_HIGH    = 2'b10,
      IPR_LVL_HIGHEST = 2'b11
   } ipr_lvl_t;

   // ----------------------------------------------------------------
   // Machine cycle states
   // ----------------------------------------------------------------
   localparam int STATES_PER_CYCLE = 4;
   typedef enum logic [1:0]
   {
      IPR_C1 = 2'b00,
      IPR_C2 = 2'b01,
      IPR_C3 = 2'b10,
      IPR_C4 = 2'b11
   } ipr_state_t;

   // Reset values
   localparam logic [3:0] RST_IN_SERVICE = 4'h0;
   localparam logic [3:0] RST_VECTOR     = 4'h0;

endpackage

// ===== verilog/ipr_poll_if.sv
// Carrier between the resolver top and its arbiter.
// Assumes both ends run on mclk.
interface ipr_poll_if;
   logic [ipr_pkg::NUM_SRC-1:0]     req;
   logic [2*ipr_pkg::NUM_SRC-1:0]   lvl;
   logic                            found;
   logic [ipr_pkg::SRC_W-1:0]       win_src;
   ipr_pkg::ipr_lvl_t               win_lvl;

   modport top (output req, output lvl, input found, input win_src,
                input win_lvl);
   modport arb (input req, input lvl, output found, output win_src,
                output win_lvl);
endinterface

// ===== verilog/ipr_arbiter.sv
// Combinational arbiter: highest level first, then fixed hierarchy.
// Assumes the request vector is already gated by the enables.
module ipr_arbiter
(
   ipr_poll_if.arb  p
);

   // ----------------------------------------------------------------
   // Scan from lowest hierarchy to highest so index 0 wins last
   // ----------------------------------------------------------------
   always_comb
   begin
      p.found   = 1'b0;
      p.win_src = '0;
      p.win_lvl = ipr_pkg::IPR_LVL_LOWEST;
      for (int i = ipr_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (p.req[i] && (!p.found ||
             ipr_pkg::ipr_lvl_t'(p.lvl[2*i +: 2]) >= p.win_lvl)) // [R4] [R5]
         begin
            p.found   = 1'b1;
            p.win_src = ipr_pkg::SRC_W'(i);
            p.win_lvl = ipr_pkg::ipr_lvl_t'(p.lvl[2*i +: 2]); // [R1]
         end
      end
   end

endmodule // ipr_arbiter

// ===== test/ipr_resolver_assertions.sv
// Checker for the interrupt priority resolver outputs.
// Assumes it is bound to ipr_resolver and sees only its ports.
module ipr_resolver_assertions
#(
   parameter int NUM_SRC = 13
)
(
   input wire logic                        mclk,
   input wire logic                        sys_rst,
   input wire logic                        global_enable,
   input wire logic                        last_cycle_of_insn,
   input wire logic                        insn_writes_int_cfg,
   input wire logic                        return_from_interrupt,
   input wire logic                        long_subroutine_call,
   input wire logic [ipr_pkg::SRC_W-1:0]   vector_source,
   input wire logic [ipr_pkg::NUM_LVL-1:0] in_service,
   input wire logic [1:0]                  machine_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_call;
      long_subroutine_call;
   endsequence
   // Return read on the C4 edge with something still in service
   sequence s_ret;
      machine_state == 2'h3 && return_from_interrupt && last_cycle_of_insn
         && in_service != 4'h0;
   endsequence

   a_state_step: assert property (1'b1 |=>
      machine_state == $past(machine_state) + 2'h1)
      else $error("machine state did not advance");
   a_call_in_c1: assert property (s_call |-> machine_state == 2'h0)
      else $error("call outside first state");
   a_call_one_shot: assert property (s_call |=>
      !long_subroutine_call [*3])
      else $error("second call within one machine cycle");
   a_call_strobes: assert property (s_call |->
      $past(last_cycle_of_insn) && !$past(insn_writes_int_cfg)
      && !$past(return_from_interrupt))
      else $error("call despite core status");
   a_call_enabled: assert property (s_call |->
      $past(global_enable, 4))
      else $error("call with global enable low");
   a_new_level: assert property (s_call |->
      (in_service & ~$past(in_service)) > $past(in_service))
      else $error("call did not take a higher free level");
   a_vector_hold: assert property (!long_subroutine_call |->
      $stable(vector_source))
      else $error("vector changed without a call");
   a_return_clear: assert property (s_ret |=>
      $onehot($past(in_service) ^ in_service)
      && (($past(in_service) ^ in_service) > in_service))
      else $error("return did not clear the top level");
   a_service_quiet: assert property (machine_state != 2'h0 |->
      $stable(in_service))
      else $error("in service changed mid cycle");
endmodule // ipr_resolver_assertions

bind ipr_resolver ipr_resolver_assertions #(.NUM_SRC(NUM_SRC)) i_chk
(
   .mclk(mclk), .sys_rst(sys_rst), .global_enable(global_enable),
   .last_cycle_of_insn(last_cycle_of_insn),
   .insn_writes_int_cfg(insn_writes_int_cfg),
   .return_from_interrupt(return_from_interrupt),
   .long_subroutine_call(long_subroutine_call),
   .vector_source(vector_source), .in_service(in_service),
   .machine_state(machine_state)
);

// ===== test/ipr_core_model.sv
// Core sequencer stand-in: flags the last machine cycle of each insn.
// Assumes machine_state comes from the resolver on the same clock.
module ipr_core_model
(
   input wire logic       mclk,
   input wire logic [1:0] machine_state,
   input wire logic [1:0] insn_cycles,
   output logic           last_cycle_of_insn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_ff = 2'h0;
   logic [1:0] nxt_cnt;
   initial last_cycle_of_insn = 1'b1;
   // Decided in C1 and held all cycle, as the resolver reads it at C4
   always @(negedge mclk)
   begin
      if (machine_state === 2'h0)
      begin
         nxt_cnt = last_cycle_of_insn ? 2'h0 : cnt_ff + 2'h1;
         cnt_ff <= nxt_cnt;
         last_cycle_of_insn <= (nxt_cnt + 2'h1 >= insn_cycles);
      end
   end
endmodule // ipr_core_model

// ===== test/interrupt_priority_resolver_tb.sv
// Bench for ipr_resolver: tie order walk, then random polls.
// Assumes the core model and checker are compiled before it.
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) \
   begin errors++; $display("wrong value %s exp %0h got %0h", nm, ex, \
   got); end end
module interrupt_priority_resolver_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {time t; logic c; logic [3:0] s, v;} ipr_note_t;
   logic        mclk = 1'b0, sys_rst = 1'b1, gen = 1'b0;
   logic        cfg = 1'b0, ret = 1'b0, last, call;
   logic [13:0] fl = 14'h0;
   logic [12:0] en = 13'h0, lo = 13'h0, hi = 13'h0;
   logic [1:0]  cyc = 2'h1, mst;
   logic [3:0]  vsrc, isv, exp_is = 4'h0, exp_src = 4'h0;
   logic [31:0] seed = 32'h3F;
   int          errors = 0, check_count = 0;
   ipr_note_t   q[$];

   always #10 mclk = ~mclk;

   ipr_resolver #(.NUM_SRC(13)) i_dut
   (
      .mclk(mclk), .sys_rst(sys_rst), .ext_int0_flag(fl[0]),
      .brownout_flag(fl[1]), .watchdog_int_flag(fl[2]),
      .timer0_overflow_flag(fl[3]), .twi_flag(fl[4]),
      .converter_done_flag(fl[5]), .ext_int1_flag(fl[6]),
      .keypad_flag(fl[7]), .comparator1_flag(fl[8]),
      .timer1_overflow_flag(fl[9]), .comparator2_flag(fl[10]),
      .serial_rx_flag(fl[11]), .serial_tx_flag(fl[12]),
      .pwm_brake_flag(fl[13]), .global_enable(gen), .source_enable(en),
      .priority_low_bits(lo), .priority_high_bits(hi),
      .last_cycle_of_insn(last), .insn_writes_int_cfg(cfg),
      .return_from_interrupt(ret), .long_subroutine_call(call),
      .vector_source(vsrc), .in_service(isv), .machine_state(mst)
   );
   ipr_core_model i_core
   (
      .mclk(mclk), .machine_state(mst), .insn_cycles(cyc),
      .last_cycle_of_insn(last)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // One machine cycle: drive in C1, predict at C4, compare next C1
   task automatic poll(logic [13:0] f, logic [12:0] e, l, h,
                       logic g, c, r);
      logic [12:0] req;
      logic [1:0]  wl, lv;
      logic [3:0]  ws;
      logic        fnd;
      ipr_note_t   n;
      @(negedge mclk iff mst === 2'h0);
      {fl, en, lo, hi} = {f, e, l, h};
      {gen, cfg, ret} = {g, c, r};
      @(negedge mclk iff mst === 2'h3);
      req = {f[13], f[12] | f[11], f[10:0]} & e & {13{g}};
      {fnd, wl, ws} = 7'h0;
      for (int k = 0; k < 13; k++)
      begin
         lv = {h[k], l[k]};
         if (req[k] && (!fnd || lv > wl))
            {fnd, wl, ws} = {1'b1, lv, 4'(k)};
      end
      n.c = fnd && last && !c && !r && (exp_is >> wl) == 4'h0;
      if (n.c)
         {exp_is[wl], exp_src} = {1'b1, ws};
      else if (r && last)
         for (int k = 3; k >= 0; k--)
            if (exp_is[k])
            begin
               exp_is[k] = 1'b0;
               break;
            end
      {n.t, n.s, n.v} = {$time, exp_src, exp_is};
      q.push_back(n);
   endtask

   always @(negedge mclk)
   begin
      if (mst === 2'h0 && q.size() > 0 && q[0].t < $time)
      begin
         `CHK("call", q[0].c, call)
         `CHK("vector", q[0].s, vsrc)
         `CHK("in_service", q[0].v, isv)
         void'(q.pop_front());
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      logic [31:0] r1, r2, r3;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      // Every slot ties with all lower ones, then a return frees it
      for (int s = 0; s < 13; s++)
      begin
         poll(14'h3FFF << (s < 12 ? s : 13), 13'h1FFF, {13{s[0]}},
              {13{s[1]}}, 1'b1, 1'b0, 1'b0);
         poll(14'h0, 13'h1FFF, 13'h0, 13'h0, 1'b1, 1'b0, 1'b1);
      end
      $display("tie order test done");
      for (int i = 0; i < 300; i++)
      begin
         {r1, r2, r3} = {rnd(), rnd(), rnd()};
         cyc = (r3[1:0] == 2'h0) ? 2'h1 : r3[1:0];
         poll(r1[13:0] & r2[13:0], r1[26:14] | r3[12:0], r2[12:0],
              r3[25:13], r2[31:29] != 3'h0, r3[28:26] == 3'h0,
              r3[31:30] == 2'h0);
      end
      $display("random poll test done");
      repeat (8) @(negedge mclk);
      end_of_test();
   end

   // About 1300 cycles expected; allow several times that
   initial
   begin
      #200000;
      errors++;
      end_of_test();
   end
endmodule // interrupt_priority_resolver_tb
